// >>> rtl/erac_pkg.sv
// Constants, offsets and types shared by the RAM access control block
package erac_pkg;

  // Register offsets on the register port
  localparam logic [7:0] OFF_ECC_MODE    = 8'h00;  // protected_ram_mode_ctrl
  localparam logic [7:0] OFF_PLAIN_MODE  = 8'h04;  // plain array enable
  localparam logic [7:0] OFF_SYS_CTRL    = 8'h08;  // wait select, module stop, NMI select
  localparam logic [7:0] OFF_ECC_GUARD   = 8'h0c;  // protected_ram_write_guard
  localparam logic [7:0] OFF_PLAIN_GUARD = 8'h10;  // plain_ram_write_guard
  localparam logic [7:0] OFF_SB_CAP_EN   = 8'h14;  // single_bit_capture_enable
  localparam logic [7:0] OFF_IRQ_STATUS  = 8'h18;  // Read only
  localparam logic [7:0] OFF_IRQ_CLEAR   = 8'h1c;  // Write only, one clears
  localparam logic [7:0] OFF_IRQ_ENABLE  = 8'h20;
  localparam logic [7:0] OFF_SB_ADDR     = 8'h24;  // single_bit_error_addr
  localparam logic [7:0] OFF_DB_ADDR     = 8'h28;  // double_bit_error_addr
  localparam logic [7:0] OFF_PL_ADDR     = 8'h2c;  // plain_ram_error_addr
  localparam logic [7:0] OFF_INJ_MASK    = 8'h30;  // Test: flips stored data bits

  // Field positions
  localparam int SYS_MW_BIT     = 0;
  localparam int SYS_PSTOP_BIT  = 1;
  localparam int SYS_ESTOP_BIT  = 2;
  localparam int SYS_NMI_BIT    = 3;
  localparam int ST_PLAIN       = 0;  // Plain array parity error
  localparam int ST_SB          = 1;  // Protected array single-bit error
  localparam int ST_DB          = 2;  // Protected array double-bit error
  localparam int ST_W           = 3;
  localparam logic [7:0] GUARD_KEY = 8'ha5;  // Upper key byte of a guard write

  // Values after reset
  localparam logic RST_ECC_EN   = 1'b0;
  localparam logic RST_PLAIN_EN = 1'b1;
  localparam logic RST_MW       = 1'b0;
  localparam logic RST_STOP     = 1'b0;
  localparam logic RST_NMI_SEL  = 1'b0;
  localparam logic RST_SB_CAP   = 1'b1;

  // Address map
  localparam logic [31:0] ECC_BASE  = 32'h00ff_c000;
  localparam logic [31:0] ECC_LAST  = 32'h00ff_ffff;
  localparam int          ECC_BYTES = 16384;
  localparam int          PLAIN_BYTES_DEF = 65536;  // 131072 for the large variant

  // Access latency in clock cycles, request cycle to done cycle
  localparam logic [2:0] LAT_PLAIN      = 3'h1;
  localparam logic [2:0] LAT_MW0        = 3'h2;
  localparam logic [2:0] LAT_MW0_ERR    = 3'h3;
  localparam logic [2:0] LAT_MW1        = 3'h3;
  localparam logic [2:0] LAT_MW1_RD     = 3'h3;
  localparam logic [2:0] LAT_MW1_ECC_WR = 3'h4;
  localparam logic [2:0] LAT_MW1_ERR    = 3'h5;

  typedef enum logic [0:0] {S_IDLE, S_WAIT} erac_state_e;

endpackage : erac_pkg

// >>> rtl/erac_secded.sv
// Hamming code with overall parity: encoder and single-fix double-detect checker
`timescale 1ns/100ps
module erac_secded #(
  parameter int DW = 32,
  parameter int PW = 6
) (
  // Encode side
  input  wire logic [DW-1:0] enc_data,
  output logic      [PW:0]   enc_check,
  // Check side
  input  wire logic [DW-1:0] chk_data,
  input  wire logic [PW:0]   chk_check,
  output logic      [DW-1:0] fix_data,
  output logic               single_err,
  output logic               double_err
);

  // Codeword position of a data bit: the idx-th position that is not a power of two
  function automatic int unsigned dpos(input int unsigned idx);
    int unsigned p;
    int unsigned k;
    p = 0;
    k = 0;
    for (int unsigned c = 3; c < 256; c++) begin
      if ((c & (c - 1)) != 0) begin
        if (k == idx && p == 0) p = c;
        k++;
      end
    end
    return p;
  endfunction : dpos

  logic [DW-1:0] mask [PW];
  logic [PW-1:0] syn;
  logic [PW-1:0] enc_p;

  // Parity masks and per-bit correction; a syndrome naming a check bit leaves data alone
  for (genvar i = 0; i < DW; i++) begin : g_bit
    localparam int unsigned P = dpos(i);
    for (genvar j = 0; j < PW; j++) begin : g_msk
      assign mask[j][i] = P[j];
    end
    assign fix_data[i] = chk_data[i] ^ (single_err && (syn == P[PW-1:0]));
  end

  // Check bits and syndrome
  for (genvar j = 0; j < PW; j++) begin : g_chk
    assign enc_p[j] = ^(enc_data & mask[j]);
    assign syn[j]   = chk_check[j] ^ (^(chk_data & mask[j]));
  end

  // Overall parity separates odd (fixable) from even (detect only) errors
  assign enc_check  = {^{enc_data, enc_p}, enc_p};
  assign single_err = ^{chk_data, chk_check};
  assign double_err = !single_err && (syn != '0);

endmodule : erac_secded

// >>> rtl/erac_top.sv
// Access control for a plain parity RAM array and an error-correcting RAM array
//
// The register addresses and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/100ps
module erac_top #(
  parameter int PLAIN_BYTES = erac_pkg::PLAIN_BYTES_DEF,
  parameter int DW          = 32
) (
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          rst,
  // Memory bus from the CPU
  input  wire logic          mem_req,
  input  wire logic          mem_we,
  input  wire logic [3:0]    mem_be,
  input  wire logic [31:0]   mem_addr,
  input  wire logic [DW-1:0] mem_wdata,
  output logic               mem_done,
  output logic      [DW-1:0] mem_rdata,
  // Register port
  input  wire logic [7:0]    reg_addr,
  input  wire logic [31:0]   reg_wdata,
  input  wire logic          reg_wr,
  input  wire logic          reg_rd,
  output logic      [31:0]   reg_rdata,
  // Error interrupts
  output logic               irq,
  output logic               nmi
);

  localparam int PW       = 6;
  localparam int ECC_WDS  = erac_pkg::ECC_BYTES / 4;
  localparam int ECC_AW   = $clog2(ECC_WDS);
  localparam int PL_WDS   = PLAIN_BYTES / 4;
  localparam int PL_AW    = $clog2(PL_WDS);

  typedef struct packed {
    erac_pkg::erac_state_e  fsm;
    logic [2:0]             cnt;
    logic                   done;
    logic [DW-1:0]          rdata;
    logic [31:0]            reg_rdata;
    logic                   ecc_en;
    logic                   plain_en;
    logic                   mw;
    logic                   plain_stop;
    logic                   ecc_stop;
    logic                   nmi_sel;
    logic                   ecc_unlock;
    logic                   plain_unlock;
    logic                   sb_cap_en;
    logic [erac_pkg::ST_W-1:0] status;
    logic [erac_pkg::ST_W-1:0] irq_en;
    logic [31:0]            sb_addr;
    logic [31:0]            db_addr;
    logic [31:0]            pl_addr;
    logic [DW-1:0]          inj_mask;
    logic                   irq;
    logic                   nmi;
  } erac_st_s;

  erac_st_s st_r;
  erac_st_s st_nxt;

  // Storage arrays: check bits above data, parity above data
  logic [DW+PW:0] ecc_mem [ECC_WDS];
  logic [DW:0]    pl_mem  [PL_WDS];

  logic                ecc_hit;
  logic                pl_hit;
  logic                ecc_ok;
  logic                pl_ok;
  logic                accept;
  logic [ECC_AW-1:0]   ecc_idx;
  logic [PL_AW-1:0]    pl_idx;
  logic [DW+PW:0]      ecc_word;
  logic [DW:0]         pl_word;
  logic [DW-1:0]       ecc_fix;
  logic [DW-1:0]       ecc_old;
  logic [DW-1:0]       ecc_merge;
  logic [DW-1:0]       pl_merge;
  logic [PW:0]         enc_check;
  logic                sb;
  logic                db;
  logic                ecc_err;
  logic                pl_perr;
  logic                ev_pl;
  logic                ev_sb;
  logic                ev_db;
  logic                ecc_wr;
  logic                pl_wr;
  logic [2:0]          lat;
  logic [DW-1:0]       rd_val;

  // Address decode of both windows
  assign ecc_hit = (mem_addr >= erac_pkg::ECC_BASE) && (mem_addr <= erac_pkg::ECC_LAST);
  assign pl_hit  = mem_addr < 32'(PLAIN_BYTES);
  assign ecc_idx = mem_addr[ECC_AW+1:2];
  assign pl_idx  = mem_addr[PL_AW+1:2];
  // A stopped or disabled array still answers, so the bus never hangs
  assign ecc_ok  = ecc_hit && !st_r.ecc_stop;
  assign pl_ok   = pl_hit && !ecc_hit && st_r.plain_en && !st_r.plain_stop;
  assign accept  = mem_req && (st_r.fsm == erac_pkg::S_IDLE);

  // Asynchronous array reads feed the checkers in the request cycle
  assign ecc_word = ecc_mem[ecc_idx];
  assign pl_word  = pl_mem[pl_idx];
  assign pl_perr  = ^pl_word;

  erac_secded #(
    .DW (DW),
    .PW (PW)
  ) u_secded (
    .enc_data   (ecc_merge),
    .enc_check  (enc_check),
    .chk_data   (ecc_word[DW-1:0]),
    .chk_check  (ecc_word[DW+PW:DW]),
    .fix_data   (ecc_fix),
    .single_err (sb),
    .double_err (db)
  );

  // Corrected data only while correction is on; a double error passes uncorrected
  assign ecc_old = st_r.ecc_en ? ecc_fix : ecc_word[DW-1:0];
  assign ecc_err = st_r.ecc_en && (sb || db);

  // Byte merge; partial writes are read-modify-write so protected array writes also check the old word
  for (genvar b = 0; b < DW / 8; b++) begin : g_merge
    assign ecc_merge[8*b +: 8] = mem_be[b] ? mem_wdata[8*b +: 8] : ecc_old[8*b +: 8];
    assign pl_merge[8*b +: 8]  = mem_be[b] ? mem_wdata[8*b +: 8] : pl_word[8*b +: 8];
  end

  // Error events of the accepted access
  assign ev_pl  = accept && pl_ok && !mem_we && pl_perr;
  assign ev_sb  = accept && ecc_ok && st_r.ecc_en && sb;
  assign ev_db  = accept && ecc_ok && st_r.ecc_en && db;
  assign ecc_wr = accept && ecc_ok && mem_we;
  assign pl_wr  = accept && pl_ok && mem_we;
  assign rd_val = mem_we ? '0 : (ecc_ok ? ecc_old : (pl_ok ? pl_word[DW-1:0] : '0));

  // Latency selection for the accepted access
  always_comb begin
    lat = erac_pkg::LAT_PLAIN;
    if (ecc_ok) begin
      if (!st_r.mw) begin
        lat = ecc_err ? erac_pkg::LAT_MW0_ERR : erac_pkg::LAT_MW0;
      end else if (!st_r.ecc_en) begin
        lat = erac_pkg::LAT_MW1;
      end else if (ecc_err) begin
        lat = erac_pkg::LAT_MW1_ERR;
      end else if (mem_we) begin
        lat = erac_pkg::LAT_MW1_ECC_WR;
      end else begin
        lat = erac_pkg::LAT_MW1_RD;
      end
    end
  end

  // Array writes; the inject mask lets a test plant stored bit errors
  always_ff @(posedge clk) begin
    if (ecc_wr) begin
      ecc_mem[ecc_idx] <= {enc_check, ecc_merge ^ st_r.inj_mask};
    end
    if (pl_wr) begin
      pl_mem[pl_idx] <= {^pl_merge, pl_merge ^ st_r.inj_mask};
    end
  end

  // Next state: access sequencer, registers, flags and interrupts
  always_comb begin
    st_nxt           = st_r;
    st_nxt.done      = 1'b0;
    st_nxt.reg_rdata = '0;
    // Access sequencer: done pulse lands lat cycles after the request cycle
    case (st_r.fsm)
      erac_pkg::S_IDLE: begin
        if (accept) begin
          st_nxt.rdata = rd_val;
          if (lat == erac_pkg::LAT_PLAIN) begin
            st_nxt.done = 1'b1;
          end else begin
            st_nxt.fsm = erac_pkg::S_WAIT;
            st_nxt.cnt = lat - 3'h2;
          end
        end
      end
      erac_pkg::S_WAIT: begin
        if (st_r.cnt == 3'h0) begin
          st_nxt.done = 1'b1;
          st_nxt.fsm  = erac_pkg::S_IDLE;
        end else begin
          st_nxt.cnt = st_r.cnt - 3'h1;
        end
      end
      default: st_nxt.fsm = erac_pkg::S_IDLE;
    endcase
    // Register writes; guarded mode registers relock after a taken write
    if (reg_wr) begin
      if (reg_addr == erac_pkg::OFF_ECC_MODE) begin
        if (st_r.ecc_unlock) begin
          st_nxt.ecc_en     = reg_wdata[0];
          st_nxt.ecc_unlock = 1'b0;
        end
      end else if (reg_addr == erac_pkg::OFF_PLAIN_MODE) begin
        if (st_r.plain_unlock) begin
          st_nxt.plain_en     = reg_wdata[0];
          st_nxt.plain_unlock = 1'b0;
        end
      end else if (reg_addr == erac_pkg::OFF_SYS_CTRL) begin
        st_nxt.mw         = reg_wdata[erac_pkg::SYS_MW_BIT];
        st_nxt.plain_stop = reg_wdata[erac_pkg::SYS_PSTOP_BIT];
        st_nxt.ecc_stop   = reg_wdata[erac_pkg::SYS_ESTOP_BIT];
        st_nxt.nmi_sel    = reg_wdata[erac_pkg::SYS_NMI_BIT];
      end else if (reg_addr == erac_pkg::OFF_ECC_GUARD) begin
        if (reg_wdata[15:8] == erac_pkg::GUARD_KEY) st_nxt.ecc_unlock = reg_wdata[0];
      end else if (reg_addr == erac_pkg::OFF_PLAIN_GUARD) begin
        if (reg_wdata[15:8] == erac_pkg::GUARD_KEY) st_nxt.plain_unlock = reg_wdata[0];
      end else if (reg_addr == erac_pkg::OFF_SB_CAP_EN) begin
        st_nxt.sb_cap_en = reg_wdata[0];
      end else if (reg_addr == erac_pkg::OFF_IRQ_CLEAR) begin
        st_nxt.status = st_r.status & ~reg_wdata[erac_pkg::ST_W-1:0];
      end else if (reg_addr == erac_pkg::OFF_IRQ_ENABLE) begin
        st_nxt.irq_en = reg_wdata[erac_pkg::ST_W-1:0];
      end else if (reg_addr == erac_pkg::OFF_INJ_MASK) begin
        st_nxt.inj_mask = reg_wdata[DW-1:0];
      end
    end
    // Flags set after the clear so an event in the clear cycle survives
    if (ev_pl) begin
      st_nxt.status[erac_pkg::ST_PLAIN] = 1'b1;
      st_nxt.pl_addr = mem_addr;
    end
    if (ev_sb) begin
      st_nxt.status[erac_pkg::ST_SB] = 1'b1;
      if (st_r.sb_cap_en) st_nxt.sb_addr = mem_addr;
    end
    if (ev_db) begin
      st_nxt.status[erac_pkg::ST_DB] = 1'b1;
      st_nxt.db_addr = mem_addr;
    end
    // One enabled flag drives either the NMI or the maskable line
    st_nxt.irq = !st_nxt.nmi_sel && (|(st_nxt.status & st_nxt.irq_en));
    st_nxt.nmi = st_nxt.nmi_sel && (|(st_nxt.status & st_nxt.irq_en));
    // Register reads answer in the next cycle only; unmapped offsets read zero
    if (reg_rd) begin
      if (reg_addr == erac_pkg::OFF_ECC_MODE) begin
        st_nxt.reg_rdata = {31'h0, st_r.ecc_en};
      end else if (reg_addr == erac_pkg::OFF_PLAIN_MODE) begin
        st_nxt.reg_rdata = {31'h0, st_r.plain_en};
      end else if (reg_addr == erac_pkg::OFF_SYS_CTRL) begin
        st_nxt.reg_rdata = {28'h0, st_r.nmi_sel, st_r.ecc_stop, st_r.plain_stop, st_r.mw};
      end else if (reg_addr == erac_pkg::OFF_ECC_GUARD) begin
        st_nxt.reg_rdata = {31'h0, st_r.ecc_unlock};
      end else if (reg_addr == erac_pkg::OFF_PLAIN_GUARD) begin
        st_nxt.reg_rdata = {31'h0, st_r.plain_unlock};
      end else if (reg_addr == erac_pkg::OFF_SB_CAP_EN) begin
        st_nxt.reg_rdata = {31'h0, st_r.sb_cap_en};
      end else if (reg_addr == erac_pkg::OFF_IRQ_STATUS) begin
        st_nxt.reg_rdata = {29'h0, st_r.status};
      end else if (reg_addr == erac_pkg::OFF_IRQ_ENABLE) begin
        st_nxt.reg_rdata = {29'h0, st_r.irq_en};
      end else if (reg_addr == erac_pkg::OFF_SB_ADDR) begin
        st_nxt.reg_rdata = st_r.sb_addr;
      end else if (reg_addr == erac_pkg::OFF_DB_ADDR) begin
        st_nxt.reg_rdata = st_r.db_addr;
      end else if (reg_addr == erac_pkg::OFF_PL_ADDR) begin
        st_nxt.reg_rdata = st_r.pl_addr;
      end else if (reg_addr == erac_pkg::OFF_INJ_MASK) begin
        st_nxt.reg_rdata = 32'(st_r.inj_mask);
      end
    end
  end

  // State register with synchronous reset
  always_ff @(posedge clk) begin
    if (rst) begin
      st_r              <= '0;
      st_r.fsm          <= erac_pkg::S_IDLE;
      st_r.ecc_en       <= erac_pkg::RST_ECC_EN;
      st_r.plain_en     <= erac_pkg::RST_PLAIN_EN;
      st_r.mw           <= erac_pkg::RST_MW;
      st_r.plain_stop   <= erac_pkg::RST_STOP;
      st_r.ecc_stop     <= erac_pkg::RST_STOP;
      st_r.nmi_sel      <= erac_pkg::RST_NMI_SEL;
      st_r.sb_cap_en    <= erac_pkg::RST_SB_CAP;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state register
  assign mem_done  = st_r.done;
  assign mem_rdata = st_r.rdata;
  assign reg_rdata = st_r.reg_rdata;
  assign irq       = st_r.irq;
  assign nmi       = st_r.nmi;

  // Checks on latency, flags and guarding
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_lat_m0_off: assert property (
    accept && ecc_ok && !st_r.mw && !st_r.ecc_en |-> ##1 !mem_done ##1 mem_done)
    else $error("wait0 no-ecc access not two cycles");
  a_lat_m0_clean: assert property (
    accept && ecc_ok && !st_r.mw && st_r.ecc_en && !(sb || db) |-> ##1 !mem_done ##1 mem_done)
    else $error("wait0 clean ecc access not two cycles");
  a_lat_m0_err: assert property (
    accept && ecc_ok && !st_r.mw && ecc_err |-> ##1 !mem_done [*2] ##1 mem_done)
    else $error("wait0 ecc error access not three cycles");
  a_lat_m1_off: assert property (
    accept && ecc_ok && st_r.mw && !st_r.ecc_en |-> ##1 !mem_done [*2] ##1 mem_done)
    else $error("wait1 no-ecc access not three cycles");
  a_lat_m1_write: assert property (
    accept && ecc_ok && st_r.mw && st_r.ecc_en && !(sb || db) && mem_we |-> ##1 !mem_done [*3] ##1 mem_done)
    else $error("wait1 clean ecc write not four cycles");
  a_lat_m1_err: assert property (
    accept && ecc_ok && st_r.mw && ecc_err |-> ##1 !mem_done [*4] ##1 mem_done)
    else $error("wait1 ecc error access not five cycles");
  a_plain_single: assert property (
    accept && !ecc_ok |=> mem_done && st_r.fsm == erac_pkg::S_IDLE)
    else $error("plain access not single cycle");
  a_double_capture: assert property (
    ev_db |=> st_r.status[erac_pkg::ST_DB] && st_r.db_addr == $past(mem_addr))
    else $error("double error not flagged with address");
  a_parity_flag: assert property (
    ev_pl |=> st_r.status[erac_pkg::ST_PLAIN] && st_r.pl_addr == $past(mem_addr))
    else $error("plain parity error not flagged");
  a_err_to_int: assert property (
    ev_sb && st_r.irq_en[erac_pkg::ST_SB] |=> (irq != nmi) && (nmi == st_r.nmi_sel))
    else $error("enabled error did not raise the selected interrupt");
  a_sb_hold: assert property (
    ev_sb && !st_r.sb_cap_en |=> $stable(st_r.sb_addr))
    else $error("single error address captured while disabled");
  a_guard_lock: assert property (
    reg_wr && reg_addr == erac_pkg::OFF_ECC_MODE && !st_r.ecc_unlock |=> $stable(st_r.ecc_en))
    else $error("locked mode register changed");

  c_single_fix: cover property (ev_sb && !mem_we);
  c_double_det: cover property (ev_db);
  c_parity_det: cover property (ev_pl);
  c_m1_write: cover property (accept && ecc_ok && st_r.mw && st_r.ecc_en && mem_we);

endmodule : erac_top

// >>> tb/erac_cpu_model.sv
// CPU memory bus master model that times each access
`timescale 1ns/100ps
module erac_cpu_model (
  // Clock
  input  wire logic        clk,
  // Request
  output logic             mem_req,
  output logic             mem_we,
  output logic [3:0]       mem_be,
  output logic [31:0]      mem_addr,
  output logic [31:0]      mem_wdata,
  // Answer
  input  wire logic        mem_done,
  input  wire logic [31:0] mem_rdata
);
  // Idle bus at time zero
  initial begin
    mem_req   = 1'b0;
    mem_we    = 1'b0;
    mem_be    = 4'h0;
    mem_addr  = 32'h0;
    mem_wdata = 32'h0;
  end

  // One word access; address and write data are inverted once taken so stale values never look valid
  task automatic access(input logic we, input logic [31:0] a, input logic [31:0] d,
                        output logic [31:0] rd, output int n);
    @(posedge clk);
    mem_req   <= 1'b1;
    mem_we    <= we;
    mem_be    <= 4'hf;
    mem_addr  <= a;
    mem_wdata <= d;
    n = 0;
    @(posedge clk);
    mem_req   <= 1'b0;
    mem_addr  <= ~a;
    mem_wdata <= ~d;
    repeat (8) begin
      #1;
      n++;
      if (mem_done === 1'b1) break;
      @(posedge clk);
    end
    rd = mem_rdata;
  endtask : access
endmodule : erac_cpu_model

// >>> tb/erac_top_tb_top.sv
// Self-checking bench for the RAM access control block
`timescale 1ns/100ps
module erac_top_tb_top;
  logic              clk, rst, mem_req, mem_we, mem_done, reg_wr, reg_rd, irq, nmi;
  logic [3:0]        mem_be;
  logic [7:0]        reg_addr;
  logic [31:0]       mem_addr, mem_wdata, mem_rdata, reg_wdata, reg_rdata;
  int                bad_count = 0;
  int                total_checks = 0;
  int                cycles = 0;
  localparam logic [31:0] EA = erac_pkg::ECC_BASE;
  localparam logic [31:0] EL = erac_pkg::ECC_LAST - 32'h3;
  localparam logic [31:0] D1 = 32'h1234_5678;
  localparam logic [31:0] D2 = 32'h9abc_def0;

  erac_top u_dut (.clk, .rst, .mem_req, .mem_we, .mem_be, .mem_addr, .mem_wdata, .mem_done,
                  .mem_rdata, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq, .nmi);
  erac_cpu_model u_cpu (.clk, .mem_req, .mem_we, .mem_be, .mem_addr, .mem_wdata, .mem_done,
                        .mem_rdata);

  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Ceiling well above the fewer than two hundred cycles the run needs
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      final_report();
    end
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : final_report

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask : rd

  // Access with latency and returned data judged together
  task automatic mem(input logic we, input logic [31:0] a, input logic [31:0] d, input int lat,
                     input logic [31:0] exp);
    logic [31:0] r;
    int          n;
    u_cpu.access(we, a, d, r, n);
    chk(32'(n), 32'(lat));
    chk(r, exp);
  endtask : mem

  task automatic t_plain();
    mem(1'b1, 32'h0000_fffc, D2, 1, 32'h0);
    mem(1'b0, 32'h0000_fffc, 32'h0, 1, D2);
    mem(1'b0, 32'h0001_0000, 32'h0, 1, 32'h0);
  endtask : t_plain

  // Words are first written with correction off, so no check runs on unwritten contents
  task automatic t_ecc_off();
    for (int i = 0; i < 3; i++) begin
      mem(1'b1, EA + 32'(4 * i), D1, 2, 32'h0);
    end
    mem(1'b1, EL, D2, 2, 32'h0);
    mem(1'b0, EL, 32'h0, 2, D2);
    mem(1'b0, EA - 32'h4, 32'h0, 1, 32'h0);
  endtask : t_ecc_off

  task automatic t_guard();
    wr(erac_pkg::OFF_ECC_MODE, 32'h1);
    rd(erac_pkg::OFF_ECC_MODE, 32'h0);
    wr(erac_pkg::OFF_ECC_GUARD, 32'h0000_a501);
    wr(erac_pkg::OFF_ECC_MODE, 32'h1);
    rd(erac_pkg::OFF_ECC_MODE, 32'h1);
    rd(erac_pkg::OFF_ECC_GUARD, 32'h0);
  endtask : t_guard

  task automatic t_ecc_mw0();
    wr(erac_pkg::OFF_IRQ_ENABLE, 32'h7);
    mem(1'b0, EA, 32'h0, 2, D1);
    wr(erac_pkg::OFF_INJ_MASK, 32'h1);
    mem(1'b1, EA, D1, 2, 32'h0);
    wr(erac_pkg::OFF_INJ_MASK, 32'h3);
    mem(1'b1, EA + 32'h4, D1, 2, 32'h0);
    wr(erac_pkg::OFF_INJ_MASK, 32'h0);
    mem(1'b0, EA, 32'h0, 3, D1);
    rd(erac_pkg::OFF_IRQ_STATUS, 32'h2);
    rd(erac_pkg::OFF_SB_ADDR, EA);
    chk({31'h0, irq}, 32'h1);
    wr(erac_pkg::OFF_IRQ_CLEAR, 32'h7);
    wr(erac_pkg::OFF_SYS_CTRL, 32'h8);
    mem(1'b0, EA + 32'h4, 32'h0, 3, D1 ^ 32'h3);
    rd(erac_pkg::OFF_DB_ADDR, EA + 32'h4);
    chk({30'h0, nmi, irq}, 32'h2);
    // Single error at a new address with capture disabled: flag sets, address holds
    wr(erac_pkg::OFF_INJ_MASK, 32'h4);
    mem(1'b1, EL, D2, 2, 32'h0);
    wr(erac_pkg::OFF_INJ_MASK, 32'h0);
    wr(erac_pkg::OFF_SB_CAP_EN, 32'h0);
    mem(1'b0, EL, 32'h0, 3, D2);
    rd(erac_pkg::OFF_SB_ADDR, EA);
    rd(erac_pkg::OFF_IRQ_STATUS, 32'h6);
    wr(erac_pkg::OFF_SB_CAP_EN, 32'h1);
    wr(erac_pkg::OFF_IRQ_CLEAR, 32'h7);
    rd(erac_pkg::OFF_IRQ_STATUS, 32'h0);
    chk({31'h0, nmi}, 32'h0);
  endtask : t_ecc_mw0

  task automatic t_mw1();
    wr(erac_pkg::OFF_SYS_CTRL, 32'h1);
    mem(1'b1, EA + 32'h8, D2, 4, 32'h0);
    mem(1'b0, EA + 32'h8, 32'h0, 3, D2);
    mem(1'b0, EA, 32'h0, 5, D1);
    mem(1'b1, EA + 32'h4, D2, 5, 32'h0);
    wr(erac_pkg::OFF_IRQ_CLEAR, 32'h7);
    wr(erac_pkg::OFF_ECC_GUARD, 32'h0000_a501);
    wr(erac_pkg::OFF_ECC_MODE, 32'h0);
    mem(1'b1, EA + 32'h8, D1, 3, 32'h0);
    mem(1'b0, EA + 32'h8, 32'h0, 3, D1);
    wr(erac_pkg::OFF_SYS_CTRL, 32'h0);
  endtask : t_mw1

  task automatic t_plain_err();
    wr(erac_pkg::OFF_INJ_MASK, 32'h1);
    mem(1'b1, 32'h100, D1, 1, 32'h0);
    wr(erac_pkg::OFF_INJ_MASK, 32'h0);
    mem(1'b0, 32'h100, 32'h0, 1, D1 ^ 32'h1);
    rd(erac_pkg::OFF_IRQ_STATUS, 32'h1);
    rd(erac_pkg::OFF_PL_ADDR, 32'h100);
    wr(erac_pkg::OFF_IRQ_CLEAR, 32'h7);
    // Plain array stopped: a written word reads back as zero in one cycle
    wr(erac_pkg::OFF_SYS_CTRL, 32'h2);
    mem(1'b0, 32'h0000_fffc, 32'h0, 1, 32'h0);
    wr(erac_pkg::OFF_SYS_CTRL, 32'h0);
    wr(erac_pkg::OFF_PLAIN_GUARD, 32'h0000_a501);
    wr(erac_pkg::OFF_PLAIN_MODE, 32'h0);
    mem(1'b0, 32'h0000_fffc, 32'h0, 1, 32'h0);
    wr(erac_pkg::OFF_SYS_CTRL, 32'h4);
    mem(1'b0, EL, 32'h0, 1, 32'h0);
  endtask : t_plain_err

  // Reset, then the scenarios in order; later ones rely on words written earlier
  initial begin
    rst       = 1'b1;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 8'h0;
    reg_wdata = 32'h0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_plain();
    t_ecc_off();
    t_guard();
    t_ecc_mw0();
    t_mw1();
    t_plain_err();
    final_report();
  end
endmodule : erac_top_tb_top
